// ### hdl/ccmc_pkg.sv
package ccmc_pkg;
	// register map
	localparam logic [7:0]  CCMC_OFS_MODE_CFG   = 8'h18;
	localparam logic [7:0]  CCMC_OFS_COMPARE    = 8'h1c;
	localparam logic [7:0]  CCMC_OFS_STATUS     = 8'h20;
	localparam logic [15:0] CCMC_MODE_CFG_RESET = 16'h0000;
	localparam logic [15:0] CCMC_COMPARE_RESET  = 16'h0000;
	// field positions in channel_mode_config_1
	localparam int CCMC_DIR_LSB   = 0;
	localparam int CCMC_FAST_BIT  = 2;
	localparam int CCMC_PRE_BIT   = 3;
	localparam int CCMC_MODE_LSB  = 4;
	localparam int CCMC_CLR_BIT   = 7;
	// protection level that locks the output fields
	localparam logic [1:0]  CCMC_LOCK_LEVEL     = 2'h3;
	localparam logic [1:0]  CCMC_DIR_OUTPUT     = 2'h0;
	// axi responses
	localparam logic [1:0]  CCMC_RESP_OKAY      = 2'h0;
	localparam logic [1:0]  CCMC_RESP_SLVERR    = 2'h2;

	// channel direction codes
	typedef enum logic [1:0] {
		CCMC_DIR_OUT = 2'h0,
		CCMC_DIR_TI1 = 2'h1,
		CCMC_DIR_TI2 = 2'h2,
		CCMC_DIR_TRC = 2'h3
	} ccmc_dir_t;

	// compare output modes
	typedef enum logic [2:0] {
		CCMC_MODE_FREEZE = 3'h0,
		CCMC_MODE_SET    = 3'h1,
		CCMC_MODE_CLEAR  = 3'h2,
		CCMC_MODE_TOGGLE = 3'h3,
		CCMC_MODE_LOW    = 3'h4,
		CCMC_MODE_HIGH   = 3'h5,
		CCMC_MODE_PWM1   = 3'h6,
		CCMC_MODE_PWM2   = 3'h7
	} ccmc_mode_t;

	// channel_mode_config_1 layout
	typedef struct packed {
		logic [7:0] upper;
		logic       reference_clear_enable;
		ccmc_mode_t compare_output_mode;
		logic       compare_preload_enable;
		logic       fast_compare_enable;
		ccmc_dir_t  channel_direction_select;
	} ccmc_cfg_t;

	// timer context from the surrounding timer
	typedef struct packed {
		logic [15:0] counter;
		logic        update_event;
		logic        trigger_event;
		logic        channel_output_enable;
		logic [1:0]  protection_level;
		logic        filtered_external_trigger;
	} ccmc_timer_t;
endpackage

// ### hdl/ccmc_compare_shadow.sv
`timescale 1ns/1ps
// compare value with optional preload shadow
module ccmc_compare_shadow #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// software side
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             preload_enable,
	input  wire logic             update_event,
	// comparison side
	output logic      [WIDTH-1:0] shadow_value,
	output logic      [WIDTH-1:0] active_value
);
	import ccmc_pkg::*;

	logic [WIDTH-1:0] next_shadow_value;
	logic [WIDTH-1:0] next_active_value;

	initial begin
		if (WIDTH < 1 || WIDTH > 16) $error("compare width out of range");
	end

	// shadow always takes writes; active follows now or at update
	always_comb begin
		next_shadow_value = wr_en ? wr_data : shadow_value;
		next_active_value = active_value;
		if (!preload_enable && wr_en) begin
			next_active_value = wr_data;
		end else if (preload_enable && update_event) begin
			next_active_value = shadow_value;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow_value <= WIDTH'(CCMC_COMPARE_RESET);
			active_value <= WIDTH'(CCMC_COMPARE_RESET);
		end else begin
			shadow_value <= next_shadow_value;
			active_value <= next_active_value;
		end
	end

	no_preload_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_en && !preload_enable |=> active_value == $past(wr_data))
		else $error("direct compare write not applied");
	preload_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		preload_enable && !update_event |=> active_value == $past(active_value))
		else $error("preloaded compare changed without update");
	preload_update_a: assert property (@(posedge aclk) disable iff (!aresetn)
		preload_enable && update_event |=> active_value == $past(shadow_value))
		else $error("shadow not transferred on update");
endmodule

// ### hdl/ccmc_reference_gen.sv
`timescale 1ns/1ps
// compare reference signal generator
module ccmc_reference_gen #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// configuration
	input  wire ccmc_pkg::ccmc_mode_t mode,
	input  wire logic                fast_enable,
	input  wire logic                clear_enable,
	input  wire logic                is_output,
	// timer context
	input  wire logic [WIDTH-1:0]    counter,
	input  wire logic [WIDTH-1:0]    compare,
	input  wire logic                trigger_event,
	input  wire logic                filtered_external_trigger,
	// result
	output logic                     reference,
	output logic                     match
);
	import ccmc_pkg::*;

	logic next_reference;
	logic next_match;
	logic is_equal;
	logic hit;

	// equality on this cycle; fast path lets a trigger act as a match
	assign is_equal = (counter == compare);
	assign hit      = is_equal || (fast_enable && trigger_event);

	// level decided once a cycle from mode, comparison and clear
	always_comb begin
		next_reference = reference;
		next_match     = is_equal;
		if (is_output) begin
			unique case (mode)
				CCMC_MODE_FREEZE: next_reference = reference;
				CCMC_MODE_SET:    if (hit) next_reference = 1'b1;
				CCMC_MODE_CLEAR:  if (hit) next_reference = 1'b0;
				CCMC_MODE_TOGGLE: if (hit) next_reference = ~reference;
				CCMC_MODE_LOW:    next_reference = 1'b0;
				CCMC_MODE_HIGH:   next_reference = 1'b1;
				// level is the comparison re-taken every cycle, so it also moves on entry to the mode
				CCMC_MODE_PWM1:   next_reference = (counter < compare);
				CCMC_MODE_PWM2:   next_reference = (counter > compare);
			endcase
		end
		if (clear_enable && filtered_external_trigger) begin
			next_reference = 1'b0;
		end
	end

	// reference updated on the timer clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reference <= 1'b0;
			match     <= 1'b0;
		end else begin
			reference <= next_reference;
			match     <= next_match;
		end
	end

	freeze_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_FREEZE && !(clear_enable && filtered_external_trigger)
		|=> reference == $past(reference))
		else $error("freeze mode changed reference");
	set_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_SET && is_equal && !clear_enable |=> reference)
		else $error("set on match failed");
	toggle_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_TOGGLE && is_equal && !clear_enable |=> reference != $past(reference))
		else $error("toggle on match failed");
	force_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_HIGH && !clear_enable ##1 is_output && mode == CCMC_MODE_HIGH |-> reference)
		else $error("forced high not held");
	pwm_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_PWM1 && !clear_enable |=> reference == $past(counter < compare))
		else $error("pwm mode one level wrong");
	pwm_two_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_PWM2 && !clear_enable |=> reference == $past(counter > compare))
		else $error("pwm mode two level wrong");
	ref_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clear_enable && filtered_external_trigger |=> !reference)
		else $error("external clear ignored");
	fast_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
		is_output && mode == CCMC_MODE_SET && fast_enable && trigger_event && !clear_enable |=> reference)
		else $error("fast trigger path not taken");

	toggle_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == CCMC_MODE_TOGGLE && is_equal ##1 !reference ##[1:40] reference);
	pwm_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
		mode == CCMC_MODE_PWM1 && reference ##[1:40] !reference);
endmodule

// ### hdl/ccmc_channel_mode_ctrl.sv
`timescale 1ns/1ps
module ccmc_channel_mode_ctrl #(
	parameter int CMP_WIDTH = 16
) (
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write address
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// axi4-lite read data
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// timer context
	input  wire ccmc_pkg::ccmc_timer_t timer_in,
	// channel outputs
	output logic                      compare_reference_signal,
	output ccmc_pkg::ccmc_dir_t       channel_direction_select,
	output logic                      compare_match,
	output logic [CMP_WIDTH-1:0]      compare_value
);
	import ccmc_pkg::*;

	initial begin
		if (CMP_WIDTH < 1 || CMP_WIDTH > 16) $error("CMP_WIDTH must be 1 to 16");
	end

	////////////////////////////////////////////////////////////////////////
	// write channel: address and data caught in either order

	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        next_aw_held;
	logic        next_w_held;
	logic [7:0]  next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic        next_bvalid;
	logic [1:0]  next_bresp;
	logic        wr_fire;

	// word address decode shared by both directions
	function automatic logic is_mapped(input logic [7:0] addr);
		return addr == CCMC_OFS_MODE_CFG || addr == CCMC_OFS_COMPARE || addr == CCMC_OFS_STATUS;
	endfunction

	// byte address rounded down to its word
	function automatic logic [7:0] word_addr(input logic [7:0] addr);
		return {addr[7:2], 2'b00};
	endfunction

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

	// hold each half until both are present, then answer
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = word_addr(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (is_mapped(aw_addr) && aw_addr != CCMC_OFS_STATUS) ? CCMC_RESP_OKAY : CCMC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CCMC_RESP_OKAY;
		end else begin
			aw_held      <= next_aw_held;
			w_held       <= next_w_held;
			aw_addr      <= next_aw_addr;
			w_data       <= next_w_data;
			w_strb       <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp  <= next_bresp;
		end
	end

	// write channel holding and answer
	aw_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awvalid && s_axi_awready |=> aw_held && aw_addr == $past(word_addr(s_axi_awaddr)))
		else $error("write address not captured");
	w_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_wvalid && s_axi_wready |=> w_held && w_data == $past(s_axi_wdata) && w_strb == $past(s_axi_wstrb))
		else $error("write data not captured");
	aw_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		aw_held && !w_held |=> aw_held && aw_addr == $past(aw_addr))
		else $error("held write address lost");
	w_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		w_held && !aw_held |=> w_held && w_data == $past(w_data))
		else $error("held write data lost");
	write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid && !aw_held && !w_held)
		else $error("write not answered");
	bresp_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && aw_addr == CCMC_OFS_STATUS |=> s_axi_bresp == CCMC_RESP_SLVERR)
		else $error("status write accepted");
	bresp_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && aw_addr == CCMC_OFS_MODE_CFG |=> s_axi_bresp == CCMC_RESP_OKAY)
		else $error("config write refused");
	bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	write_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");

	////////////////////////////////////////////////////////////////////////
	// channel_mode_config_1 with its write locks

	ccmc_cfg_t   cfg;
	ccmc_cfg_t   next_cfg;
	ccmc_cfg_t   wr_cfg;
	logic        cfg_wr;
	logic        cmp_wr;
	logic        locked;
	logic [15:0] wr_half;
	logic [15:0] cfg_bits;

	assign cfg_bits = cfg;
	// byte lanes merged over the present value
	assign wr_half = {w_strb[1] ? w_data[15:8] : cfg_bits[15:8], w_strb[0] ? w_data[7:0] : cfg_bits[7:0]};
	assign wr_cfg  = ccmc_cfg_t'(wr_half);
	assign cfg_wr  = wr_fire && aw_addr == CCMC_OFS_MODE_CFG;
	assign cmp_wr  = wr_fire && aw_addr == CCMC_OFS_COMPARE && (w_strb[1:0] != 2'b00);
	assign locked  = timer_in.protection_level == CCMC_LOCK_LEVEL && cfg.channel_direction_select == CCMC_DIR_OUT;

	// field-wise update honouring enable and protection locks
	always_comb begin
		next_cfg = cfg;
		if (cfg_wr) begin
			next_cfg.upper                  = wr_cfg.upper;
			next_cfg.fast_compare_enable    = wr_cfg.fast_compare_enable;
			next_cfg.reference_clear_enable = wr_cfg.reference_clear_enable;
			if (!timer_in.channel_output_enable) begin
				next_cfg.channel_direction_select = wr_cfg.channel_direction_select;
			end
			if (!locked) begin
				next_cfg.compare_preload_enable = wr_cfg.compare_preload_enable;
				next_cfg.compare_output_mode    = wr_cfg.compare_output_mode;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= ccmc_cfg_t'(CCMC_MODE_CFG_RESET);
		end else begin
			cfg <= next_cfg;
		end
	end

	// direction handed to the capture side
	assign channel_direction_select = cfg.channel_direction_select;

	// config writes land field by field
	dir_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_wr && !timer_in.channel_output_enable
		|=> cfg.channel_direction_select == $past(wr_cfg.channel_direction_select))
		else $error("direction write not applied");
	lock_open_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_wr && !locked |=> cfg.compare_output_mode == $past(wr_cfg.compare_output_mode)
			&& cfg.compare_preload_enable == $past(wr_cfg.compare_preload_enable))
		else $error("unlocked mode write not applied");
	cfg_idle_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg_wr |=> cfg == $past(cfg))
		else $error("config changed without a write");
	field_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_wr |=> cfg.fast_compare_enable == $past(wr_cfg.fast_compare_enable) && cfg.upper == $past(wr_cfg.upper)
			&& cfg.reference_clear_enable == $past(wr_cfg.reference_clear_enable))
		else $error("free config fields not stored");
	dir_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timer_in.channel_output_enable |=> cfg.channel_direction_select == $past(cfg.channel_direction_select))
		else $error("direction changed while channel enabled");
	mode_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
		locked |=> cfg.compare_output_mode == $past(cfg.compare_output_mode)
			&& cfg.compare_preload_enable == $past(cfg.compare_preload_enable))
		else $error("locked mode field modified");
	cfg_write_c: cover property (@(posedge aclk) disable iff (!aresetn) cfg_wr && !locked);
	lock_hit_c: cover property (@(posedge aclk) disable iff (!aresetn) cfg_wr && locked);

	////////////////////////////////////////////////////////////////////////
	// compare value and reference generation

	logic [CMP_WIDTH-1:0] cmp_shadow;

	ccmc_compare_shadow #(
		.WIDTH(CMP_WIDTH)
	) u_shadow (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.wr_en         (cmp_wr),
		.wr_data       (w_data[CMP_WIDTH-1:0]),
		.preload_enable(cfg.compare_preload_enable),
		.update_event  (timer_in.update_event),
		.shadow_value  (cmp_shadow),
		.active_value  (compare_value)
	);

	// compare writes with no low lanes leave the value alone
	cmp_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && aw_addr == CCMC_OFS_COMPARE && w_strb[1:0] == 2'b00 && !cfg.compare_preload_enable
		|=> compare_value == $past(compare_value))
		else $error("compare changed without a write");

	ccmc_reference_gen #(
		.WIDTH(CMP_WIDTH)
	) u_ref (
		.aclk                     (aclk),
		.aresetn                  (aresetn),
		.mode                     (cfg.compare_output_mode),
		.fast_enable              (cfg.fast_compare_enable),
		.clear_enable             (cfg.reference_clear_enable),
		.is_output                (cfg.channel_direction_select == CCMC_DIR_OUT),
		.counter                  (timer_in.counter[CMP_WIDTH-1:0]),
		.compare                  (compare_value),
		.trigger_event            (timer_in.trigger_event),
		.filtered_external_trigger(timer_in.filtered_external_trigger),
		.reference                (compare_reference_signal),
		.match                    (compare_match)
	);

	////////////////////////////////////////////////////////////////////////
	// read channel: one cycle to answer

	logic        next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0]  next_rresp;
	logic [7:0]  rd_addr;

	assign s_axi_arready = !s_axi_rvalid;
	assign rd_addr       = word_addr(s_axi_araddr);

	// status word: reference, match, lock state
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = is_mapped(rd_addr) ? CCMC_RESP_OKAY : CCMC_RESP_SLVERR;
			unique case (1'b1)
				rd_addr == CCMC_OFS_MODE_CFG: next_rdata = {16'h0000, cfg_bits};
				rd_addr == CCMC_OFS_COMPARE:  next_rdata = {16'h0000, 16'(cmp_shadow)};
				rd_addr == CCMC_OFS_STATUS:   next_rdata = {29'h0000_0000, locked, compare_match, compare_reference_signal};
				default:                      next_rdata = 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= CCMC_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rresp;
		end
	end

	read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	// read answers stand and carry the addressed word
	rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer dropped early");
	read_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");
	unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && !is_mapped(rd_addr)
		|=> s_axi_rresp == CCMC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	rresp_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && is_mapped(rd_addr) |=> s_axi_rresp == CCMC_RESP_OKAY)
		else $error("mapped read refused");
	cfg_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rd_addr == CCMC_OFS_MODE_CFG |=> s_axi_rdata == {16'h0000, $past(cfg_bits)})
		else $error("config read wrong");
	cmp_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rd_addr == CCMC_OFS_COMPARE
		|=> s_axi_rdata[CMP_WIDTH-1:0] == $past(cmp_shadow))
		else $error("compare read wrong");
	status_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && rd_addr == CCMC_OFS_STATUS
		|=> s_axi_rdata == {29'h0000_0000, $past({locked, compare_match, compare_reference_signal})})
		else $error("status read wrong");
	read_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
endmodule

// ### tb/ccmc_tb.sv
`timescale 1ns/1ps
`define chk(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
	import ccmc_pkg::*;
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr  = 8'h00;
	logic        awvalid = 1'b0;
	logic        awready;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        wvalid  = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready  = 1'b0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready  = 1'b0;
	ccmc_timer_t tmr     = '{counter: 16'h0001, default: '0};
	logic        ref_out;
	ccmc_dir_t   dir_out;
	logic        match_out;
	logic [15:0] cmp_out;
	int          num_errors  = 0;
	int          comparisons = 0;
	logic [1:0]  resp;
	logic [31:0] rd;
	always #4 aclk = ~aclk;
	ccmc_channel_mode_ctrl i_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.timer_in(tmr), .compare_reference_signal(ref_out), .channel_direction_select(dir_out),
		.compare_match(match_out), .compare_value(cmp_out)
	);
	////////////////////////////////////////////////////////////////////////////////
	// verdict and run end
	task end_sim();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// a wait that ran out of cycles
	task fail_wait();
		num_errors++;
		$display("MISMATCH handshake expected %h seen %h", 1'b1, 1'b0);
		end_sim();
	endtask
	// one axi4-lite write, address and data offered together
	task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic aw_ok, w_ok, awt, wt, bt;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		bt    = 1'b0;
		n     = 0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(aw_ok && w_ok && bt)) begin
			@(negedge aclk);
			awt = awvalid && awready;
			wt  = wvalid && wready;
			bt  = bready && bvalid;
			r   = bresp;
			@(posedge aclk);
			if (awt) begin
				awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (wt) begin
				wvalid <= 1'b0;
				w_ok = 1'b1;
			end
			if (bt) bready <= 1'b0;
			n++;
			if (n > 100) fail_wait();
		end
	endtask
	// one axi4-lite read
	task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int   n;
		logic rt, art;
		rt = 1'b0;
		n  = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!rt) begin
			@(negedge aclk);
			rt = rready && rvalid;
			art = arvalid && arready;
			d  = rdata;
			r  = rresp;
			@(posedge aclk);
			if (art) arvalid <= 1'b0;
			if (rt) rready <= 1'b0;
			n++;
			if (n > 100) fail_wait();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// helpers for configuration and timer context
	task cfg(input logic [7:0] v);
		axi_write(CCMC_OFS_MODE_CFG, {24'h00_0000, v}, resp);
	endtask
	task settle();
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	task set_cnt(input logic [15:0] v);
		@(posedge aclk);
		tmr.counter <= v;
	endtask
	task pulse(input logic upd);
		@(posedge aclk);
		if (upd) tmr.update_event <= 1'b1;
		else tmr.trigger_event <= 1'b1;
		@(posedge aclk);
		tmr.update_event  <= 1'b0;
		tmr.trigger_event <= 1'b0;
	endtask
	task chk_ref(input logic e);
		settle();
		`chk("reference", e, ref_out)
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(CCMC_OFS_MODE_CFG, rd, resp);
		`chk("cfg reset", {16'h0000, CCMC_MODE_CFG_RESET}, rd)
		axi_read(8'h40, rd, resp);
		`chk("unmapped rresp", CCMC_RESP_SLVERR, resp)
		axi_write(CCMC_OFS_STATUS, 32'h0000_0007, resp);
		`chk("status bresp", CCMC_RESP_SLVERR, resp)
		// direction codes, writable while the channel is off
		for (int d = 3; d >= 0; d--) begin
			cfg(8'(d));
			settle();
			`chk("direction", 2'(d), dir_out)
		end
		@(posedge aclk);
		tmr.channel_output_enable <= 1'b1;
		cfg(8'h02);
		settle();
		`chk("direction locked", CCMC_DIR_OUT, dir_out)
		@(posedge aclk);
		tmr.channel_output_enable <= 1'b0;
		// compare value direct, then through the shadow
		axi_write(CCMC_OFS_COMPARE, 32'h0000_0064, resp);
		settle();
		`chk("compare direct", 16'h0064, cmp_out)
		`chk("write bresp", CCMC_RESP_OKAY, resp)
		cfg(8'h08);
		axi_write(CCMC_OFS_COMPARE, 32'h0000_00c8, resp);
		settle();
		`chk("compare held", 16'h0064, cmp_out)
		axi_read(CCMC_OFS_COMPARE, rd, resp);
		`chk("compare shadow", 32'h0000_00c8, rd)
		pulse(1'b1);
		settle();
		`chk("compare updated", 16'h00c8, cmp_out)
		cfg(8'h00);
		axi_write(CCMC_OFS_COMPARE, 32'h0000_0064, resp);
		// forced low, then trigger pulses with and without fast path
		cfg(8'h40);
		chk_ref(1'b0);
		cfg(8'h10);
		pulse(1'b0);
		chk_ref(1'b0);
		cfg(8'h14);
		pulse(1'b0);
		chk_ref(1'b1);
		// clear and set on match
		cfg(8'h20);
		set_cnt(16'h0064);
		chk_ref(1'b0);
		`chk("match", 1'b1, match_out)
		set_cnt(16'h0001);
		cfg(8'h10);
		set_cnt(16'h0064);
		chk_ref(1'b1);
		set_cnt(16'h0001);
		// one-cycle matches toggle once each
		cfg(8'h30);
		for (int t = 0; t < 2; t++) begin
			set_cnt(16'h0064);
			set_cnt(16'h0001);
			chk_ref(1'(t));
		end
		// freeze ignores a match
		cfg(8'h00);
		set_cnt(16'h0064);
		chk_ref(1'b1);
		set_cnt(16'h0001);
		// forced high, cleared by the external trigger only when enabled
		cfg(8'h50);
		chk_ref(1'b1);
		cfg(8'hd0);
		@(posedge aclk);
		tmr.filtered_external_trigger <= 1'b1;
		chk_ref(1'b0);
		cfg(8'h50);
		chk_ref(1'b1);
		@(posedge aclk);
		tmr.filtered_external_trigger <= 1'b0;
		// forced low, then pwm with a defined compare value, entered from freeze
		cfg(8'h40);
		chk_ref(1'b0);
		cfg(8'h00);
		set_cnt(16'h0032);
		cfg(8'h60);
		chk_ref(1'b1);
		set_cnt(16'h0096);
		chk_ref(1'b0);
		cfg(8'h70);
		chk_ref(1'b1);
		set_cnt(16'h0064);
		chk_ref(1'b0);
		set_cnt(16'h0032);
		chk_ref(1'b0);
		// protection level three locks mode and preload of an output
		@(posedge aclk);
		tmr.protection_level <= CCMC_LOCK_LEVEL;
		cfg(8'h58);
		axi_read(CCMC_OFS_MODE_CFG, rd, resp);
		`chk("cfg locked", 32'h0000_0070, rd)
		axi_read(CCMC_OFS_STATUS, rd, resp);
		`chk("status locked", 32'h0000_0004, rd)
		@(posedge aclk);
		tmr.protection_level <= 2'h0;
		cfg(8'h58);
		axi_read(CCMC_OFS_MODE_CFG, rd, resp);
		`chk("cfg unlocked", 32'h0000_0058, rd)
		end_sim();
	end
endmodule
